// >>> rtl/lpc_pkg.sv
package lpc_pkg;

   // ----------------------------------------------------------------
   // Register map (register indices on the 32-bit AXI4-Lite bus)
   // ----------------------------------------------------------------
   // The printed offsets are not all multiples of four, so each is kept
   // as an index and the byte address is four times the index.
   localparam logic [15:0] IDX_CTRL = 16'h1103;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h110b;
   localparam logic [15:0] IDX_ERR_CNT_B3 = 16'h1114;
   localparam logic [15:0] IDX_ERR_CNT_B2 = 16'h1115;
   localparam logic [15:0] IDX_ERR_CNT_B1 = 16'h1116;
   localparam logic [15:0] IDX_ERR_CNT_B0 = 16'h1117;
   localparam logic [15:0] IDX_SD_SET_HI = 16'h1142;
   localparam logic [15:0] IDX_SD_SET_LO = 16'h1143;
   localparam logic [15:0] IDX_SD_CLR_HI = 16'h1144;
   localparam logic [15:0] IDX_SD_CLR_LO = 16'h1145;
   localparam logic [15:0] IDX_SD_SET_WIN_HI = 16'h1146;
   localparam logic [15:0] IDX_SD_SET_WIN_LO = 16'h1147;
   localparam logic [15:0] IDX_SD_CLR_WIN_HI = 16'h1148;
   localparam logic [15:0] IDX_SD_CLR_WIN_LO = 16'h1149;
   localparam logic [15:0] IDX_DEFECT_STATE = 16'h114a;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_TALLY_BIT = 1;
   localparam int CTRL_SD_ON_BIT = 5;
   localparam int CTRL_SF_ON_BIT = 6;
   localparam int IRQ_B2_BIT = 4;
   localparam int IRQ_SD_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WR_MASK = 8'h7f;
   localparam logic [15:0] SD_SET_RESET = 16'hffff;
   localparam logic [15:0] SD_CLR_RESET = 16'h0000;
   localparam logic [15:0] SD_WIN_RESET = 16'h0008;
   localparam logic [31:0] CNT_MAX = 32'hffffffff;
   localparam logic [4:0] MAX_BIT_ERRS = 5'h18;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // One byte of the framed receive stream; the framer flags the bytes.
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic frame_start;
      logic in_parity_span;
      logic b2_byte;
      logic [1:0] b2_index;
   } line_byte_t;

   // Per-frame error report handed to the transmit side.
   typedef struct packed {
      logic valid;
      logic [4:0] bit_errs;
   } b2_report_t;

   typedef enum logic [1:0] {
      RESP_OKAY = 2'b00,
      RESP_SLVERR = 2'b10
   } axi_resp_t;

endpackage

// >>> rtl/line_parity_check_sd_detect.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
// Functional notes
// - Compute even BIP-8 over line overhead and envelope bytes per frame.
// - Compare each frame's parity against B2 bytes of the following frame.
// - B2 error drives interrupt low and sets status bit 4, cleared on read.
// - B2 errors advance a 32-bit counter read as four byte registers.
// - Tally mode 1 adds one per frame with any B2 bit error.
// - Tally mode 0 adds count of errored bits, up to 24 per frame.
// - Hand B2 error information to the transmit remote error generator.
// - B2 errors feed signal-degrade detection; signal fail gets only its enable output.
// - Total errors over declare window; declare degrade when total exceeds limit.
// - While declared, total over clear window; clear when total below limit.
// - Declare and clear thresholds are independent software settings.
// - Declare and clear window lengths are independent software settings.
// - Tally mode also sets how errors count toward the degrade criteria.
// - Declaration window length is counted in frame periods.
// - Declare threshold is 16 bits in two byte registers, reset all ones.
module line_parity_check_sd_detect
   import lpc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Framed receive line
   input wire line_byte_t line_i,
   // Transmit side and defect outputs
   output b2_report_t rei_report_o,
   output logic degrade_defect_o,
   output logic fail_detect_on_o,
   output logic irq_n_o,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [31:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);

   function automatic logic [5:0] pop8(input logic [7:0] v);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < 8; i++) begin
         n = n + {5'h00, v[i]};
      end
      return n;
   endfunction

   function automatic logic [15:0] byte_index(input logic [31:0] addr);
      return addr[17:2];
   endfunction

   // ---------------------------------------------------------------
   // Parity accumulation and comparison
   // ---------------------------------------------------------------
   logic [7:0] bip_q, bip_d;
   logic [7:0] prev_bip_q, prev_bip_d;
   logic prev_ok_q, prev_ok_d;
   logic [4:0] frame_errs_q, frame_errs_d;
   logic frame_seen_q;
   logic [5:0] byte_errs;
   logic frame_end;

   assign frame_end = line_i.valid && line_i.frame_start && frame_seen_q;
   assign byte_errs = (line_i.valid && line_i.b2_byte && prev_ok_q) ?
                      pop8(line_i.data ^ prev_bip_q) : 6'h00;

   always_comb begin
      bip_d = bip_q;
      prev_bip_d = prev_bip_q;
      prev_ok_d = prev_ok_q;
      frame_errs_d = frame_errs_q + byte_errs[4:0];
      if (frame_end) begin
         // The closing frame's parity is kept to check the next frame's B2.
         prev_bip_d = bip_q;
         prev_ok_d = 1'b1;
         bip_d = 8'h00;
         frame_errs_d = 5'h00;
         if (line_i.in_parity_span) begin
            bip_d = line_i.data;
         end
      end else if (line_i.valid && line_i.in_parity_span) begin
         bip_d = bip_q ^ line_i.data;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         bip_q <= 8'h00;
         prev_bip_q <= 8'h00;
         prev_ok_q <= 1'b0;
         frame_errs_q <= 5'h00;
         frame_seen_q <= 1'b0;
      end else begin
         bip_q <= bip_d;
         prev_bip_q <= prev_bip_d;
         prev_ok_q <= prev_ok_d;
         frame_errs_q <= frame_errs_d;
         if (line_i.valid && line_i.frame_start) begin
            frame_seen_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [15:0] sd_set_q, sd_clr_q, sd_set_win_q, sd_clr_win_q;
   logic tally_per_frame;
   logic frame_has_err;
   logic [4:0] tally;

   assign tally_per_frame = ctrl_q[CTRL_TALLY_BIT];
   assign frame_has_err = frame_end && (frame_errs_q != 5'h00);
   // Both the counter and the degrade detector see the same tally.
   assign tally = !frame_end ? 5'h00 :
                  tally_per_frame ? {4'h0, frame_has_err} :
                  frame_errs_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rei_report_o <= '0;
      end else begin
         rei_report_o.valid <= frame_end;
         rei_report_o.bit_errs <= frame_end ? frame_errs_q : 5'h00;
      end
   end

   // ---------------------------------------------------------------
   // Signal-degrade detector
   // ---------------------------------------------------------------
   // Windows are consecutive blocks of frames; a true sliding sum would need
   // a per-frame history as deep as the longest window.
   logic sd_on;
   logic [15:0] win_cnt_q;
   logic [16:0] sd_sum_q;
   logic [16:0] sum_next;
   logic [15:0] win_len;
   logic win_done;
   logic sd_q;
   logic sd_change;

   assign sd_on = ctrl_q[CTRL_SD_ON_BIT];
   assign fail_detect_on_o = ctrl_q[CTRL_SF_ON_BIT];
   assign win_len = sd_q ? sd_clr_win_q : sd_set_win_q;
   assign sum_next = (sd_sum_q[16] || (sd_sum_q + {12'h000, tally}) > 17'h0ffff) ?
                     17'h10000 : sd_sum_q + {12'h000, tally};
   assign win_done = frame_end && (win_cnt_q + 16'h0001 >= win_len);
   assign sd_change = sd_on && win_done &&
                      (sd_q ? (sum_next < {1'b0, sd_clr_q}) :
                              (sum_next > {1'b0, sd_set_q}));
   assign degrade_defect_o = sd_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !sd_on) begin
         win_cnt_q <= 16'h0000;
         sd_sum_q <= 17'h00000;
         sd_q <= 1'b0;
      end else if (frame_end) begin
         win_cnt_q <= win_done ? 16'h0000 : win_cnt_q + 16'h0001;
         sd_sum_q <= win_done ? 17'h00000 : sum_next;
         sd_q <= sd_q ^ sd_change;
      end
   end

   // ---------------------------------------------------------------
   // Error counter and status
   // ---------------------------------------------------------------
   logic [31:0] err_cnt_q;
   logic [32:0] cnt_sum;
   logic [23:0] snap_q;
   logic [7:0] irq_q;
   logic rd_fire;
   logic [15:0] rd_idx;
   logic rd_status, rd_cnt_top;

   assign cnt_sum = {1'b0, err_cnt_q} + {28'h0000000, tally};
   assign irq_n_o = (irq_q == 8'h00);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         err_cnt_q <= 32'h00000000;
      end else if (cnt_sum[32]) begin
         err_cnt_q <= CNT_MAX;
      end else begin
         err_cnt_q <= cnt_sum[31:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         snap_q <= 24'h000000;
      end else if (rd_fire && rd_cnt_top) begin
         snap_q <= err_cnt_q[23:0];
      end
   end

   // Set wins over the clearing read.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         irq_q <= 8'h00;
      end else begin
         irq_q <= (rd_fire && rd_status) ? 8'h00 : irq_q;
         if (frame_has_err) begin
            irq_q[IRQ_B2_BIT] <= 1'b1;
         end
         if (sd_change || (sd_q && !sd_on)) begin
            irq_q[IRQ_SD_BIT] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic aw_held_q, w_held_q;
   logic [15:0] aw_idx_q;
   logic [7:0] wbyte_q;
   logic wr_go;
   logic wr_hit;

   assign s_axi_awready_o = !aw_held_q && !s_axi_bvalid_o;
   assign s_axi_wready_o = !w_held_q && !s_axi_bvalid_o;
   assign wr_go = aw_held_q && w_held_q;
   assign wr_hit = (aw_idx_q == IDX_CTRL) ||
                   (aw_idx_q >= IDX_SD_SET_HI && aw_idx_q <= IDX_SD_CLR_WIN_LO);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_idx_q <= 16'h0000;
         wbyte_q <= 8'h00;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_q <= 1'b1;
            aw_idx_q <= byte_index(s_axi_awaddr_i);
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_q <= 1'b1;
            wbyte_q <= s_axi_wstrb_i[0] ? s_axi_wdata_i[7:0] : 8'h00;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ctrl_q <= CTRL_RESET;
         sd_set_q <= SD_SET_RESET;
         sd_clr_q <= SD_CLR_RESET;
         sd_set_win_q <= SD_WIN_RESET;
         sd_clr_win_q <= SD_WIN_RESET;
      end else if (wr_go) begin
         unique case (aw_idx_q)
            IDX_CTRL: ctrl_q <= wbyte_q & CTRL_WR_MASK;
            IDX_SD_SET_HI: sd_set_q[15:8] <= wbyte_q;
            IDX_SD_SET_LO: sd_set_q[7:0] <= wbyte_q;
            IDX_SD_CLR_HI: sd_clr_q[15:8] <= wbyte_q;
            IDX_SD_CLR_LO: sd_clr_q[7:0] <= wbyte_q;
            IDX_SD_SET_WIN_HI: sd_set_win_q[15:8] <= wbyte_q;
            IDX_SD_SET_WIN_LO: sd_set_win_q[7:0] <= wbyte_q;
            IDX_SD_CLR_WIN_HI: sd_clr_win_q[15:8] <= wbyte_q;
            IDX_SD_CLR_WIN_LO: sd_clr_win_q[7:0] <= wbyte_q;
            default: ;
         endcase
      end
   end

   logic [7:0] rd_byte;
   logic rd_hit;

   assign s_axi_arready_o = !s_axi_rvalid_o;
   assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
   assign rd_idx = byte_index(s_axi_araddr_i);
   assign rd_status = (rd_idx == IDX_IRQ_STATUS);
   assign rd_cnt_top = (rd_idx == IDX_ERR_CNT_B3);

   always_comb begin
      rd_hit = 1'b1;
      unique case (rd_idx)
         IDX_CTRL: rd_byte = ctrl_q;
         IDX_IRQ_STATUS: rd_byte = irq_q;
         IDX_ERR_CNT_B3: rd_byte = err_cnt_q[31:24];
         IDX_ERR_CNT_B2: rd_byte = snap_q[23:16];
         IDX_ERR_CNT_B1: rd_byte = snap_q[15:8];
         IDX_ERR_CNT_B0: rd_byte = snap_q[7:0];
         IDX_SD_SET_HI: rd_byte = sd_set_q[15:8];
         IDX_SD_SET_LO: rd_byte = sd_set_q[7:0];
         IDX_SD_CLR_HI: rd_byte = sd_clr_q[15:8];
         IDX_SD_CLR_LO: rd_byte = sd_clr_q[7:0];
         IDX_SD_SET_WIN_HI: rd_byte = sd_set_win_q[15:8];
         IDX_SD_SET_WIN_LO: rd_byte = sd_set_win_q[7:0];
         IDX_SD_CLR_WIN_HI: rd_byte = sd_clr_win_q[15:8];
         IDX_SD_CLR_WIN_LO: rd_byte = sd_clr_win_q[7:0];
         IDX_DEFECT_STATE: rd_byte = {7'h00, sd_q};
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h00000000;
         s_axi_rresp_o <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= {24'h000000, rd_byte};
         s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

endmodule

// >>> verification/line_parity_check_sd_detect_sva.sv
`timescale 1ns/10ps
module lpc_checker
   import lpc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Line and defect side
   input wire line_byte_t line_i,
   input wire b2_report_t rei_report_o,
   input wire logic degrade_defect_o,
   input wire logic irq_n_o,
   // Register bus handshakes
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_b2_irq_low: assert property (
      rei_report_o.valid && rei_report_o.bit_errs != 5'h00 |-> !irq_n_o)
      else $error("interrupt not low after a parity error");
   chk_rei_bit_cap: assert property (
      rei_report_o.valid |-> rei_report_o.bit_errs <= MAX_BIT_ERRS)
      else $error("more errored bits reported than one frame can hold");
   chk_rei_one_pulse: assert property (rei_report_o.valid |=> !rei_report_o.valid)
      else $error("frame report longer than one cycle");
   chk_rei_frame_end: assert property (
      rei_report_o.valid |-> $past(line_i.valid && line_i.frame_start))
      else $error("frame report without a frame boundary");
   chk_sd_change_irq: assert property ($changed(degrade_defect_o) |-> ##[0:1] !irq_n_o)
      else $error("degrade change without interrupt");
   chk_irq_clear_read: assert property ($rose(irq_n_o) |->
      $past(s_axi_arvalid_i && s_axi_arready_o) || $past(s_axi_rvalid_o && s_axi_rready_i))
      else $error("interrupt released without a read");
   chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
      else $error("write answer late");
   chk_no_ar_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read address taken while answer pending");

   cover property (rei_report_o.valid && rei_report_o.bit_errs == MAX_BIT_ERRS);
   cover property ($rose(degrade_defect_o));
   cover property ($fell(degrade_defect_o));
endmodule

bind line_parity_check_sd_detect lpc_checker i_chk (
   .ref_clk_i, .rst_n_i, .line_i, .rei_report_o, .degrade_defect_o, .irq_n_o,
   .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
   .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i
);

// >>> verification/line_source.sv
`timescale 1ns/10ps
module line_source
   import lpc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Frame request
   input wire logic go_i,
   input wire logic [23:0] err_mask_i,
   // Framed line
   output line_byte_t line_o,
   output logic busy_o
);
   // ----------------------------------------------------------------
   // Frame: two section bytes, three parity bytes, seven payload bytes
   // ----------------------------------------------------------------
   logic [3:0] pos_q;
   logic [7:0] run_q, prev_q, seq_q, byte_w;
   logic [23:0] mask_q;
   logic span_w, b2_w;

   assign span_w = pos_q >= 4'h2;
   assign b2_w = span_w && pos_q <= 4'h4;
   // Each parity byte carries the last frame's result, spoiled by the mask.
   assign byte_w = b2_w ? prev_q ^ mask_q[7:0] : seq_q ^ 8'h5a;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         {busy_o, pos_q, run_q, prev_q, seq_q, mask_q} <= '0;
         line_o <= '0;
      end else if (busy_o) begin
         line_o <= '{1'b1, byte_w, pos_q == 4'h0, span_w, b2_w, pos_q[1:0] - 2'h2};
         seq_q <= seq_q + 8'h01;
         pos_q <= pos_q + 4'h1;
         if (b2_w) begin
            mask_q <= mask_q >> 8;
         end
         run_q <= span_w ? run_q ^ byte_w : run_q;
         if (pos_q == 4'hb) begin
            prev_q <= run_q ^ byte_w;
            run_q <= 8'h00;
            busy_o <= 1'b0;
         end
      end else begin
         // Data flips while idle so that a stale byte is never mistaken for a fresh one.
         line_o <= '{1'b0, ~line_o.data, 1'b0, 1'b0, 1'b0, 2'h0};
         if (go_i) begin
            busy_o <= 1'b1;
            pos_q <= 4'h0;
            mask_q <= err_mask_i;
         end
      end
   end
endmodule

// >>> verification/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb
   import lpc_pkg::*;
;
   logic ref_clk_i, rst_n_i, go, degrade, fail_on, irq_n, busy;
   logic [23:0] mask;
   line_byte_t line;
   b2_report_t rei;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [4:0] last_errs;
   int errors = 0, compares = 0, cycles = 0;

   line_source i_src (.ref_clk_i, .rst_n_i, .go_i(go), .err_mask_i(mask), .line_o(line),
      .busy_o(busy));
   line_parity_check_sd_detect i_dut (
      .ref_clk_i, .rst_n_i, .line_i(line), .rei_report_o(rei), .degrade_defect_o(degrade),
      .fail_detect_on_o(fail_on), .irq_n_o(irq_n), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(1'b1));

   // ----------------------------------------------------------------
   // Clock, frame report monitor and watchdog
   // ----------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      cycles++;
      if (rei.valid === 1'b1) begin
         last_errs <= rei.bit_errs;
      end
      if (cycles == 3000) begin
         errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Waits are ended only by the watchdog, never by a local limit.
   task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= {14'h0, idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge ref_clk_i);
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk_i); while (bvalid !== 1'b1);
      `CHK(bresp, er)
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
      araddr <= {14'h0, idx, 2'b00};
      arvalid <= 1'b1;
      do @(posedge ref_clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk_i); while (rvalid !== 1'b1);
      `CHK(rdata, {24'h0, ed})
      `CHK(rresp, er)
   endtask

   // The top byte is read first because it freezes the lower three.
   task automatic cnt(input logic [31:0] e);
      rd(IDX_ERR_CNT_B3, e[31:24], RESP_OKAY);
      rd(IDX_ERR_CNT_B2, e[23:16], RESP_OKAY);
      rd(IDX_ERR_CNT_B1, e[15:8], RESP_OKAY);
      rd(IDX_ERR_CNT_B0, e[7:0], RESP_OKAY);
   endtask

   task automatic frame(input logic [23:0] m);
      go <= 1'b1;
      mask <= m;
      @(posedge ref_clk_i);
      go <= 1'b0;
      repeat (15) @(posedge ref_clk_i);
   endtask

   initial begin
      {go, awvalid, wvalid, arvalid} = '0;
      {mask, awaddr, wdata, araddr, last_errs} = '0;
      rst_n_i = 1'b0;
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      `CHK(irq_n, 1'b1)
      rd(IDX_CTRL, 8'h00, RESP_OKAY);
      rd(IDX_SD_SET_HI, 8'hff, RESP_OKAY);
      rd(IDX_SD_SET_LO, 8'hff, RESP_OKAY);
      rd(IDX_SD_CLR_LO, 8'h00, RESP_OKAY);
      rd(IDX_SD_SET_WIN_LO, 8'h08, RESP_OKAY);
      rd(IDX_SD_CLR_WIN_LO, 8'h08, RESP_OKAY);
      cnt(32'h0);
      rd(16'h1100, 8'h00, RESP_SLVERR);
      wr(16'h1101, 8'h55, RESP_SLVERR);
      wr(IDX_CTRL, 8'hff, RESP_OKAY);
      rd(IDX_CTRL, 8'h7f, RESP_OKAY);
      `CHK(fail_on, 1'b1)
      wr(IDX_CTRL, 8'h00, RESP_OKAY);
      $display("test registers done");
      frame(24'h0);
      frame(24'h0);
      `CHK(irq_n, 1'b1)
      frame(24'h000001);
      frame(24'h0);
      `CHK(last_errs, 5'h01)
      `CHK(irq_n, 1'b0)
      rd(IDX_IRQ_STATUS, 8'h10, RESP_OKAY);
      rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
      `CHK(irq_n, 1'b1)
      frame(24'hffffff);
      frame(24'h0);
      `CHK(last_errs, MAX_BIT_ERRS)
      cnt(32'd25);
      $display("test parity done");
      wr(IDX_CTRL, 8'h02, RESP_OKAY);
      rd(IDX_ERR_CNT_B3, 8'h00, RESP_OKAY);
      frame(24'h0f00f0);
      frame(24'h0);
      `CHK(last_errs, 5'h08)
      rd(IDX_ERR_CNT_B0, 8'h19, RESP_OKAY);
      cnt(32'd26);
      rd(IDX_IRQ_STATUS, 8'h10, RESP_OKAY);
      $display("test counter done");
      wr(IDX_SD_SET_LO, 8'h02, RESP_OKAY);
      wr(IDX_SD_SET_HI, 8'h00, RESP_OKAY);
      wr(IDX_SD_SET_WIN_LO, 8'h02, RESP_OKAY);
      wr(IDX_SD_CLR_LO, 8'h01, RESP_OKAY);
      wr(IDX_SD_CLR_WIN_LO, 8'h02, RESP_OKAY);
      wr(IDX_CTRL, 8'h22, RESP_OKAY);
      repeat (6) frame(24'hffffff);
      `CHK(degrade, 1'b0)
      wr(IDX_CTRL, 8'h20, RESP_OKAY);
      repeat (6) frame(24'hffffff);
      `CHK(degrade, 1'b1)
      rd(IDX_DEFECT_STATE, 8'h01, RESP_OKAY);
      rd(IDX_IRQ_STATUS, 8'h50, RESP_OKAY);
      repeat (6) frame(24'h000001);
      `CHK(degrade, 1'b1)
      repeat (6) frame(24'h0);
      `CHK(degrade, 1'b0)
      rd(IDX_IRQ_STATUS, 8'h50, RESP_OKAY);
      $display("test degrade done");
      test_done();
   end
endmodule
